// ---- shared/pmc_pkg.sv ----
package pmc_pkg;
  // Register map and field layout of the power mode control register
  localparam logic [7:0] PWR_CTRL_IDX  = 8'h87;
  localparam logic [11:0] PWR_CTRL_ADDR = 12'h21C; // Index times four
  localparam logic [11:0] IRQ_STAT_ADDR = 12'h400;
  localparam logic [11:0] IRQ_CLR_ADDR  = 12'h404;
  localparam logic [11:0] IRQ_EN_ADDR   = 12'h408;
  localparam logic [11:0] WAKE_ADDR     = 12'h40C;
  localparam int BIT_BAUD   = 7;
  localparam int BIT_FESEL  = 6;
  localparam int BIT_COLD   = 4;
  localparam int BIT_UFHI   = 3;
  localparam int BIT_UFLO   = 2;
  localparam int BIT_DEEP   = 1;
  localparam int BIT_DOZE   = 0;
  localparam logic [7:0] PWR_CTRL_WMASK = 8'hDF; // Bit 5 reserved
  localparam logic [7:0] PWR_POR_VAL    = 8'h10;
  localparam logic [7:0] PWR_WARM_MASK  = 8'h10; // Only the cold flag kept
  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
  localparam int IRQ_W = 3;
  localparam int IRQ_DOZE_ENT = 0;
  localparam int IRQ_DEEP_ENT = 1;
  localparam int IRQ_WAKE     = 2;

  // Power state, Gray coded along run -> sleep -> wake
  typedef enum logic [1:0] {
    PMC_RUN   = 2'h0,
    PMC_DOZE  = 2'h1,
    PMC_DEEP  = 2'h2,
    PMC_WAKE  = 2'h3
  } pmc_state_e;

  // Clock gating and CPU control bundle
  typedef struct packed {
    logic cpu_clk_en;
    logic periph_clk_en;
    logic pc_hold;
    logic wake_isr;
  } pmc_ctl_s;

  // Serial port control bundle
  typedef struct packed {
    logic baud_double;
    logic frame_err_access_sel;
  } pmc_ser_s;
endpackage : pmc_pkg

// ---- hdl/pmc_state.sv ----
`timescale 1ns/1ps
// Low-power sequencer: enters doze or deep sleep, wakes on interrupt
module pmc_state (
  input  wire logic         clock,      // System clock
  input  wire logic         reset_n,    // Async reset, active low
  input  wire logic         doze_req,   // Doze bit of control register
  input  wire logic         deep_req,   // Deep sleep bit
  input  wire logic         wake_doze,  // Enabled irq alive in doze
  input  wire logic         wake_deep,  // Enabled irq alive in deep sleep
  output pmc_pkg::pmc_ctl_s ctl,        // Registered gating controls
  output logic              clr_doze,   // Pulse: clear doze bit
  output logic              clr_deep,   // Pulse: clear deep bit
  output logic              enter_doze, // Pulse: doze entered
  output logic              enter_deep, // Pulse: deep sleep entered
  output logic              woke        // Pulse: wake completed
);
  pmc_pkg::pmc_state_e state_r, state_nxt;
  pmc_pkg::pmc_ctl_s   ctl_r, ctl_nxt;

  // Next state and controls
  always_comb begin
    state_nxt    = state_r;
    clr_doze     = 1'b0;
    clr_deep     = 1'b0;
    enter_doze   = 1'b0;
    enter_deep   = 1'b0;
    woke         = 1'b0;
    case (state_r)
      pmc_pkg::PMC_RUN: begin
        if (deep_req) begin // R10
          state_nxt    = pmc_pkg::PMC_DEEP;
          enter_deep   = 1'b1;
        end else if (doze_req) begin
          state_nxt    = pmc_pkg::PMC_DOZE;
          enter_doze   = 1'b1;
        end
      end
      pmc_pkg::PMC_DOZE: begin
        if (wake_doze) begin // R13
          state_nxt = pmc_pkg::PMC_WAKE;
        end
      end
      pmc_pkg::PMC_DEEP: begin
        if (wake_deep) begin // R13
          state_nxt = pmc_pkg::PMC_WAKE;
        end
      end
      pmc_pkg::PMC_WAKE: begin
        // Clearing both on deep exit stops a trailing doze entry
        clr_deep  = 1'b1; // R8
        clr_doze  = 1'b1; // R12 R10
        woke      = 1'b1;
        state_nxt = pmc_pkg::PMC_RUN;
      end
      default: state_nxt = pmc_pkg::PMC_RUN;
    endcase
    // Clocks are back in WAKE, one cycle before the ISR is flagged
    ctl_nxt.cpu_clk_en    = (state_nxt == pmc_pkg::PMC_RUN) ||
                            (state_nxt == pmc_pkg::PMC_WAKE); // R11 R7 R13
    ctl_nxt.periph_clk_en = (state_nxt != pmc_pkg::PMC_DEEP); // R7 R11
    ctl_nxt.pc_hold       = (state_nxt == pmc_pkg::PMC_DOZE) ||
                            (state_nxt == pmc_pkg::PMC_DEEP); // R7 R11
    ctl_nxt.wake_isr      = (state_r == pmc_pkg::PMC_WAKE); // R8 R9 R12
  end

  // State registers
  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      state_r    <= pmc_pkg::PMC_RUN;
      ctl_r      <= '{1'b1, 1'b1, 1'b0, 1'b0};
    end else begin
      state_r    <= state_nxt;
      ctl_r      <= ctl_nxt;
    end
  end

  assign ctl = ctl_r;
endmodule : pmc_state

// ---- hdl/pmc_top.sv ----
`timescale 1ns/1ps
// Functional notes
// R1: Baud double doubles serial mode two rate
// R2: Access select steers serial bit seven target
// R3: Cold flag set after power-on reset
// R4: Warm reset keeps cold flag, clears rest
// R5: Software should clear cold flag after reading
// R6: User flags are plain read-back storage
// R7: Deep sleep stops CPU, peripherals, PC
// R8: Deep wake clears bit, runs waking ISR
// R9: After ISR resume past sleep instruction
// R10: Both bits set means deep sleep only
// R11: Doze stops CPU clock and PC only
// R12: Doze wake clears bit, ISR, then resume
// R13: Enabled capable interrupt wakes, clocks first
module pmc_top (
  input  wire logic        clock,         // 25 MHz system clock
  input  wire logic        reset_n,       // Power-on reset, active low
  input  wire logic        warm_reset_n,  // Other resets, active low
  input  wire logic        irq_doze_ok,   // Enabled irq pending, doze
  input  wire logic        irq_deep_ok,   // Enabled irq pending, deep
  input  wire logic [1:0]  serial_mode,   // Primary serial port mode
  input  wire logic        t1_baud_src,   // Timer 1 overflow is source
  input  wire logic        s_axi_awvalid, // AXI write address valid
  output logic             s_axi_awready, // AXI write address ready
  input  wire logic [11:0] s_axi_awaddr,  // AXI write address
  input  wire logic        s_axi_wvalid,  // AXI write data valid
  output logic             s_axi_wready,  // AXI write data ready
  input  wire logic [31:0] s_axi_wdata,   // AXI write data
  input  wire logic [3:0]  s_axi_wstrb,   // AXI byte strobes
  output logic             s_axi_bvalid,  // AXI write response valid
  input  wire logic        s_axi_bready,  // AXI write response ready
  output logic [1:0]       s_axi_bresp,   // AXI write response
  input  wire logic        s_axi_arvalid, // AXI read address valid
  output logic             s_axi_arready, // AXI read address ready
  input  wire logic [11:0] s_axi_araddr,  // AXI read address
  output logic             s_axi_rvalid,  // AXI read data valid
  input  wire logic        s_axi_rready,  // AXI read data ready
  output logic [31:0]      s_axi_rdata,   // AXI read data
  output logic [1:0]       s_axi_rresp,   // AXI read response
  output logic             cpu_clk_en,    // CPU clock gate enable
  output logic             periph_clk_en, // Peripheral clock gate enable
  output logic             pc_hold,       // Program counter frozen
  output logic             wake_isr,      // Pulse: run waking ISR first
  output logic             baud_x2,       // Serial baud doubled
  output logic             frame_err_sel, // Serial bit 7 is frame error
  output logic             irq            // Level interrupt
);
  localparam int SER_MODE1 = 1;
  localparam int SER_MODE2 = 2;
  localparam int SER_MODE3 = 3;

  logic [7:0]       pwr_r, pwr_nxt;
  logic             warm_q_r;
  logic [pmc_pkg::IRQ_W-1:0] ist_r, ist_nxt, ien_r, ien_nxt;
  logic             aw_r, aw_nxt, w_r, w_nxt, bv_r, bv_nxt;
  logic [11:0]      awa_r, awa_nxt;
  logic [31:0]      wd_r, wd_nxt;
  logic [3:0]       ws_r, ws_nxt;
  logic [1:0]       br_r, br_nxt;
  logic             rv_r, rv_nxt;
  logic [31:0]      rd_r, rd_nxt;
  logic [1:0]       rr_r, rr_nxt;
  logic             baud_r, baud_nxt, fsel_r, fsel_nxt, irq_r, irq_nxt;
  logic             do_wr, ar_take;
  logic [pmc_pkg::IRQ_W-1:0] ev, clr;
  pmc_pkg::pmc_ctl_s ctl;
  pmc_pkg::pmc_ser_s ser;
  logic clr_doze, clr_deep, e_doze, e_deep, woke;

  pmc_state u_state (
    .clock      (clock),
    .reset_n    (reset_n),
    .doze_req   (pwr_r[pmc_pkg::BIT_DOZE]),
    .deep_req   (pwr_r[pmc_pkg::BIT_DEEP]),
    .wake_doze  (irq_doze_ok),
    .wake_deep  (irq_deep_ok),
    .ctl        (ctl),
    .clr_doze   (clr_doze),
    .clr_deep   (clr_deep),
    .enter_doze (e_doze),
    .enter_deep (e_deep),
    .woke       (woke)
  );

  // AXI write channel: address and data captured in either order
  assign do_wr = aw_r && w_r && !bv_r;
  always_comb begin
    aw_nxt  = aw_r;
    w_nxt   = w_r;
    awa_nxt = awa_r;
    wd_nxt  = wd_r;
    ws_nxt  = ws_r;
    bv_nxt  = bv_r;
    br_nxt  = br_r;
    clr     = '0;
    if (s_axi_awvalid && !aw_r) begin
      aw_nxt  = 1'b1;
      awa_nxt = s_axi_awaddr;
    end
    if (s_axi_wvalid && !w_r) begin
      w_nxt  = 1'b1;
      wd_nxt = s_axi_wdata;
      ws_nxt = s_axi_wstrb;
    end
    if (do_wr) begin
      bv_nxt = 1'b1;
      aw_nxt = 1'b0;
      w_nxt  = 1'b0;
      br_nxt = pmc_pkg::RESP_OKAY;
      case (awa_r)
        pmc_pkg::PWR_CTRL_ADDR, pmc_pkg::IRQ_EN_ADDR: ;
        pmc_pkg::IRQ_CLR_ADDR:
          if (ws_r[0]) clr = wd_r[pmc_pkg::IRQ_W-1:0];
        default: br_nxt = pmc_pkg::RESP_SLVERR;
      endcase
    end
    if (bv_r && s_axi_bready) begin
      bv_nxt = 1'b0;
    end
  end

  // Control register: software writes, hardware clears on wake
  always_comb begin
    pwr_nxt = pwr_r;
    if (do_wr && ws_r[0] && awa_r == pmc_pkg::PWR_CTRL_ADDR) begin
      pwr_nxt = (wd_r[7:0] & pmc_pkg::PWR_CTRL_WMASK); // R6 R5
    end
    if (clr_deep) pwr_nxt[pmc_pkg::BIT_DEEP] = 1'b0; // R8
    if (clr_doze) pwr_nxt[pmc_pkg::BIT_DOZE] = 1'b0; // R12
    // Warm reset: only the cold flag survives
    if (!warm_q_r) pwr_nxt = pwr_r & pmc_pkg::PWR_WARM_MASK; // R4
    ien_nxt = ien_r;
    if (do_wr && ws_r[0] && awa_r == pmc_pkg::IRQ_EN_ADDR) begin
      ien_nxt = wd_r[pmc_pkg::IRQ_W-1:0];
    end
  end

  // Sticky events; a new event wins over a clear in the same cycle
  assign ev[pmc_pkg::IRQ_DOZE_ENT] = e_doze;
  assign ev[pmc_pkg::IRQ_DEEP_ENT] = e_deep;
  assign ev[pmc_pkg::IRQ_WAKE]     = woke;
  always_comb begin
    ist_nxt = (ist_r & ~clr) | ev;
    irq_nxt = |(ist_nxt & ien_nxt);
  end

  // AXI read channel, one read at a time
  assign ar_take = s_axi_arvalid && !rv_r;
  always_comb begin
    rv_nxt = rv_r;
    rd_nxt = rd_r;
    rr_nxt = rr_r;
    if (ar_take) begin
      rv_nxt = 1'b1;
      rr_nxt = pmc_pkg::RESP_OKAY;
      rd_nxt = '0;
      case (s_axi_araddr)
        pmc_pkg::PWR_CTRL_ADDR: rd_nxt[7:0] = pwr_r; // R6
        pmc_pkg::IRQ_STAT_ADDR: rd_nxt[pmc_pkg::IRQ_W-1:0] = ist_r;
        pmc_pkg::IRQ_EN_ADDR:   rd_nxt[pmc_pkg::IRQ_W-1:0] = ien_r;
        pmc_pkg::IRQ_CLR_ADDR:  rd_nxt = '0;
        pmc_pkg::WAKE_ADDR: begin
          rd_nxt[0] = ctl.pc_hold;
          rd_nxt[1] = !ctl.periph_clk_en;
        end
        default: rr_nxt = pmc_pkg::RESP_SLVERR;
      endcase
    end else if (rv_r && s_axi_rready) begin
      rv_nxt = 1'b0;
    end
  end

  // Serial steering from the control bits
  always_comb begin
    baud_nxt = pwr_r[pmc_pkg::BIT_BAUD] &&
               (serial_mode == 2'(SER_MODE2) ||
                ((serial_mode == 2'(SER_MODE1) ||
                  serial_mode == 2'(SER_MODE3)) && t1_baud_src)); // R1
    fsel_nxt = pwr_r[pmc_pkg::BIT_FESEL]; // R2
  end
  assign ser = '{baud_r, fsel_r};

  // Registers; power-on reset loads cold flag set
  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      pwr_r    <= pmc_pkg::PWR_POR_VAL; // R3
      warm_q_r <= 1'b1;
      ist_r    <= '0;
      ien_r    <= '0;
      aw_r     <= 1'b0;
      w_r      <= 1'b0;
      awa_r    <= '0;
      wd_r     <= '0;
      ws_r     <= '0;
      bv_r     <= 1'b0;
      br_r     <= pmc_pkg::RESP_OKAY;
      rv_r     <= 1'b0;
      rd_r     <= '0;
      rr_r     <= pmc_pkg::RESP_OKAY;
      baud_r   <= 1'b0;
      fsel_r   <= 1'b0;
      irq_r    <= 1'b0;
    end else begin
      pwr_r    <= pwr_nxt;
      warm_q_r <= warm_reset_n;
      ist_r    <= ist_nxt;
      ien_r    <= ien_nxt;
      aw_r     <= aw_nxt;
      w_r      <= w_nxt;
      awa_r    <= awa_nxt;
      wd_r     <= wd_nxt;
      ws_r     <= ws_nxt;
      bv_r     <= bv_nxt;
      br_r     <= br_nxt;
      rv_r     <= rv_nxt;
      rd_r     <= rd_nxt;
      rr_r     <= rr_nxt;
      baud_r   <= baud_nxt;
      fsel_r   <= fsel_nxt;
      irq_r    <= irq_nxt;
    end
  end

  // Port drive, all from flip-flops
  assign s_axi_awready = !aw_r;
  assign s_axi_wready  = !w_r;
  assign s_axi_bvalid  = bv_r;
  assign s_axi_bresp   = br_r;
  assign s_axi_arready = !rv_r;
  assign s_axi_rvalid  = rv_r;
  assign s_axi_rdata   = rd_r;
  assign s_axi_rresp   = rr_r;
  assign cpu_clk_en    = ctl.cpu_clk_en;
  assign periph_clk_en = ctl.periph_clk_en;
  assign pc_hold       = ctl.pc_hold;
  assign wake_isr      = ctl.wake_isr;
  assign baud_x2       = ser.baud_double;
  assign frame_err_sel = ser.frame_err_access_sel;
  assign irq           = irq_r;
endmodule : pmc_top

// ---- tb/pmc_top_props.sv ----
`timescale 1ns/1ps
// Gating, wake and read-hold checks at the top ports
module pmc_top_props (
  input wire logic        clock,         // Clock
  input wire logic        reset_n,       // Reset, active low
  input wire logic        irq_doze_ok,   // Doze wake source
  input wire logic        irq_deep_ok,   // Deep wake source
  input wire logic [1:0]  serial_mode,   // Serial mode
  input wire logic        t1_baud_src,   // Timer baud source
  input wire logic        s_axi_rvalid,  // Read valid
  input wire logic        s_axi_rready,  // Read ready
  input wire logic [31:0] s_axi_rdata,   // Read data
  input wire logic        cpu_clk_en,    // CPU clock gate
  input wire logic        periph_clk_en, // Peripheral gate
  input wire logic        pc_hold,       // PC frozen
  input wire logic        wake_isr,      // Wake ISR pulse
  input wire logic        baud_x2        // Baud doubled
);
  default clocking @(posedge clock); endclocking
  default disable iff (!reset_n);
  // Doubling only when the mode and the source allow it
  a_baud_cause: assert property (baud_x2 |->
    $past(serial_mode == 2'h2 || (serial_mode[0] && t1_baud_src)))
    else $error("baud doubled without cause");
  a_deep_stops: assert property (!periph_clk_en |->
    !cpu_clk_en && pc_hold) else $error("deep sleep left a clock on");
  a_doze_freeze: assert property (!cpu_clk_en |-> pc_hold)
    else $error("cpu stopped but pc runs");
  // Clocks come back one cycle before the waking ISR is flagged
  a_clock_first: assert property ($rose(cpu_clk_en) |=> wake_isr)
    else $error("no isr after clock restore");
  a_isr_once: assert property (wake_isr |=> !wake_isr && cpu_clk_en)
    else $error("isr pulse too long");
  a_isr_awake: assert property (wake_isr |->
    cpu_clk_en && periph_clk_en && !pc_hold) else $error("isr while asleep");
  a_doze_wake: assert property
    (pc_hold && periph_clk_en && irq_doze_ok |=> !pc_hold)
    else $error("doze did not wake");
  a_deep_wake: assert property
    (!periph_clk_en && irq_deep_ok |=> periph_clk_en && cpu_clk_en)
    else $error("deep sleep did not wake");
  a_stay_asleep: assert property
    (pc_hold && !irq_doze_ok && !irq_deep_ok |=> pc_hold)
    else $error("woke with no source");
  a_read_hold: assert property (s_axi_rvalid && !s_axi_rready |=>
    s_axi_rvalid && $stable(s_axi_rdata)) else $error("read data dropped");
endmodule : pmc_top_props

// ---- tb/pmc_cpu_model.sv ----
`timescale 1ns/1ps
// Interrupt sources of the CPU side that wake a sleeping core
module pmc_cpu_model (
  input  wire logic       clock,         // System clock
  input  wire logic       reset_n,       // Reset, active low
  input  wire logic [3:0] delay,         // Sleep cycles before irq
  input  wire logic       pc_hold,       // Core asleep
  input  wire logic       periph_clk_en, // Peripherals running
  input  wire logic       wake_isr,      // Waking ISR starts
  output logic            wake_doze,     // Irq alive in doze
  output logic            wake_deep      // Irq alive in deep sleep
);
  logic [3:0] cnt_r;
  // Source stays pending until its ISR runs, like a real flag
  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      cnt_r     <= 4'h0;
      wake_doze <= 1'b0;
      wake_deep <= 1'b0;
    end else if (wake_isr) begin
      wake_doze <= 1'b0;
      wake_deep <= 1'b0;
    end else if (!pc_hold) begin
      cnt_r <= 4'h0;
    end else if (cnt_r == delay) begin
      wake_doze <= periph_clk_en;
      wake_deep <= !periph_clk_en;
    end else begin
      cnt_r <= cnt_r + 4'h1;
    end
  end
endmodule : pmc_cpu_model

// ---- tb/pmc_top_tb.sv ----
`timescale 1ns/1ps
module pmc_top_tb;
  logic        clock, reset_n, warm_reset_n, irq_doze_ok, irq_deep_ok;
  logic        t1_baud_src, s_axi_awvalid, s_axi_awready, s_axi_wvalid;
  logic        s_axi_wready, s_axi_bvalid, s_axi_bready, s_axi_arvalid;
  logic        s_axi_arready, s_axi_rvalid, s_axi_rready, irq, wake_isr;
  logic        cpu_clk_en, periph_clk_en, pc_hold, baud_x2, frame_err_sel;
  logic [1:0]  serial_mode, s_axi_bresp, s_axi_rresp;
  logic [11:0] s_axi_awaddr, s_axi_araddr;
  logic [31:0] s_axi_wdata, s_axi_rdata, v;
  logic [3:0]  s_axi_wstrb, dly;
  logic [33:0] expq [$];
  logic [7:0]  modes [3] = '{8'h11, 8'h12, 8'h13};
  logic [31:0] seed = 32'h7A21773A;
  int          miscompares = 0;
  int          n_checks = 0;

  pmc_top dut (.*);
  pmc_cpu_model cpu (.clock, .reset_n, .delay(dly), .pc_hold,
    .periph_clk_en, .wake_isr, .wake_doze(irq_doze_ok),
    .wake_deep(irq_deep_ok));

  always #20 clock = ~clock;

  function logic [31:0] xs();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction : xs

  task chk(input logic [33:0] got, input logic [33:0] exp);
    n_checks++;
    if (got !== exp) begin
      miscompares++;
      $display("wrong value at %0t: got %h, expected %h", $time, got, exp);
    end
  endtask : chk

  task report_and_stop();
    if (expq.size() != 0) miscompares++;
    $display("checks %0d, mismatches %0d", n_checks, miscompares);
    if (miscompares == 0 && n_checks > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask : report_and_stop

  // Write: both channels offered together, each dropped once taken
  task wr(input logic [11:0] a, input logic [7:0] d,
          input logic [1:0] r = pmc_pkg::RESP_OKAY);
    logic aw, w;
    expq.push_back({r, 32'h0});
    aw = 1'b0;
    w = 1'b0;
    s_axi_awaddr <= a;
    s_axi_wdata <= {24'h0, d};
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    while (!(aw && w)) begin
      @(posedge clock);
      aw = aw | s_axi_awready;
      w = w | s_axi_wready;
      s_axi_awvalid <= !aw;
      s_axi_wvalid <= !w;
    end
    while (!s_axi_bvalid) @(posedge clock);
    s_axi_bready <= 1'b0;
    @(posedge clock);
  endtask : wr

  // Read: the expectation is noted now, the monitor compares it later
  task rd(input logic [11:0] a, input logic [1:0] r, input logic [7:0] d);
    expq.push_back({r, 24'h0, d});
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    do @(posedge clock); while (!s_axi_arready);
    s_axi_arvalid <= 1'b0;
    // Ready comes a cycle late so the read data must stand
    @(posedge clock);
    s_axi_rready <= 1'b1;
    do @(posedge clock); while (!s_axi_rvalid);
    s_axi_rready <= 1'b0;
    @(posedge clock);
  endtask : rd

  // Each returned word against the oldest noted expectation
  always @(posedge clock) begin
    if (s_axi_rvalid && s_axi_rready && expq.size() > 0)
      chk({s_axi_rresp, s_axi_rdata}, expq.pop_front());
    else if (s_axi_bvalid && s_axi_bready && expq.size() > 0)
      chk({s_axi_bresp, 32'h0}, expq.pop_front());
  end

  // Watchdog, far beyond the few hundred cycles the tests need
  initial begin
    repeat (20000) @(posedge clock);
    miscompares++;
    report_and_stop();
  end

  initial begin
    clock = 1'b0;
    {reset_n, s_axi_awvalid, s_axi_wvalid, s_axi_bready} = 4'h0;
    {s_axi_arvalid, s_axi_rready, serial_mode, t1_baud_src} = 5'h00;
    {s_axi_awaddr, s_axi_araddr, s_axi_wdata} = 56'h0;
    {warm_reset_n, s_axi_wstrb, dly} = 9'h1F0;
    repeat (4) @(posedge clock);
    reset_n <= 1'b1;
    @(posedge clock);
    rd(pmc_pkg::PWR_CTRL_ADDR, pmc_pkg::RESP_OKAY, 8'h10);
    // Random flags and serial settings; cold flag cleared by software
    for (int i = 0; i < 4; i++) begin
      v = xs() & 32'hCC;
      wr(pmc_pkg::PWR_CTRL_ADDR, v[7:0]);
      rd(pmc_pkg::PWR_CTRL_ADDR, pmc_pkg::RESP_OKAY, v[7:0]);
      chk(frame_err_sel, v[6]);
      for (int m = 0; m < 8; m++) begin
        serial_mode <= m[1:0];
        t1_baud_src <= m[2];
        repeat (2) @(posedge clock);
        chk(baud_x2, v[7] & (m[1:0] == 2'h2 || (m[0] && m[2])));
      end
    end
    $display("flags and serial controls done");
    // Warm reset keeps only the cold flag
    wr(pmc_pkg::PWR_CTRL_ADDR, 8'hDC);
    warm_reset_n <= 1'b0;
    repeat (2) @(posedge clock);
    warm_reset_n <= 1'b1;
    @(posedge clock);
    rd(pmc_pkg::PWR_CTRL_ADDR, pmc_pkg::RESP_OKAY, 8'h10);
    $display("warm reset done");
    wr(pmc_pkg::IRQ_EN_ADDR, 8'h00);
    wr(pmc_pkg::IRQ_CLR_ADDR, 8'h07);
    // Doze, deep sleep, and both bits together, random wake delay
    foreach (modes[i]) begin
      v = xs();
      dly <= v[3:0];
      wr(pmc_pkg::PWR_CTRL_ADDR, modes[i]);
      wait (pc_hold === 1'b1);
      @(posedge clock);
      chk(periph_clk_en, modes[i] == 8'h11);
      chk(cpu_clk_en, 1'b0);
      wait (wake_isr === 1'b1);
      @(posedge clock);
      rd(pmc_pkg::PWR_CTRL_ADDR, pmc_pkg::RESP_OKAY, 8'h10);
      chk(pc_hold, 1'b0);
      $display("sleep mode %h done", modes[i]);
    end
    // Sticky events, masked, then enabled, then cleared
    rd(pmc_pkg::IRQ_STAT_ADDR, pmc_pkg::RESP_OKAY, 8'h07);
    chk(irq, 1'b0);
    wr(pmc_pkg::IRQ_EN_ADDR, 8'h07);
    repeat (2) @(posedge clock);
    chk(irq, 1'b1);
    wr(pmc_pkg::IRQ_CLR_ADDR, 8'h07);
    repeat (2) @(posedge clock);
    chk(irq, 1'b0);
    rd(pmc_pkg::IRQ_STAT_ADDR, pmc_pkg::RESP_OKAY, 8'h00);
    rd(12'h800, pmc_pkg::RESP_SLVERR, 8'h00);
    wr(pmc_pkg::IRQ_STAT_ADDR, 8'h00, pmc_pkg::RESP_SLVERR);
    rd(pmc_pkg::WAKE_ADDR, pmc_pkg::RESP_OKAY, 8'h00);
    // Lane 0 strobe off: write answered but dropped
    s_axi_wstrb <= 4'hE;
    wr(pmc_pkg::PWR_CTRL_ADDR, 8'hCC);
    s_axi_wstrb <= 4'hF;
    rd(pmc_pkg::PWR_CTRL_ADDR, pmc_pkg::RESP_OKAY, 8'h10);
    $display("interrupt and bus errors done");
    report_and_stop();
  end
endmodule : pmc_top_tb

bind pmc_top pmc_top_props chk (.*);
